// File: design/pmc_power_mode_control.sv
// Power mode control: idle, stop and suspend sequencing with the power mode request register
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"

// Functional notes
// [RULE_01] Stop request enters stop after instruction ends
// [RULE_02] Stop halts oscillator, CPU, peripherals; external untouched
// [RULE_03] Only reset leaves stop; restart at 0x0000
// [RULE_04] Enabled clock-loss timeout resets out of stop
// [RULE_05] Software disables clock-loss detector for long stops
// [RULE_06] Regulator off in stop only if configured first
// [RULE_07] Regulator off: only pin or power cycle reset
// [RULE_08] Suspend bit halts oscillator after instruction ends
// [RULE_09] Suspend keeps state; CPU runs on other clock
// [RULE_10] USB resume or any reset ends suspend
// [RULE_11] Wake on internal oscillator continues next instruction
// [RULE_12] Configured wake interrupt serviced right after wake
// [RULE_13] Reset out of suspend restarts at 0x0000
// [RULE_14] Bits 7:2 are six plain flags, reset zero
// [RULE_15] Stop and idle bits act on one, read zero
// [RULE_16] Idle gates CPU clock only, peripherals keep clocks
// [RULE_17] Register decoded at 0x87 on every page
// [RULE_18] Enabled interrupt clears idle and resumes CPU
// [RULE_19] Regulator config bit 3; zero keeps regulator on
// [RULE_20] Suspend exit restarts oscillator and waits settling
module pmc_power_mode_control (
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire pmc_pkg::pmc_sfr_req_t SFR_REQ,
	output logic [7:0] SFR_RDATA,
	input wire logic INSTR_DONE,
	input wire logic SUSPEND_WR,
	input wire logic STOP_REG_CFG,
	input wire logic IRQ_PENDING,
	input wire logic WAKE_IRQ_EN,
	input wire logic SYSCLK_IS_HFOSC,
	input wire logic USB_RESUME,
	input wire logic RST_PIN_N,
	input wire logic OTHER_RST_REQ,
	input wire logic CLK_LOSS_EN,
	input wire logic CLK_LOSS_TIMEOUT,
	output logic CPU_CLK_EN,
	output logic PERIPH_CLK_EN,
	output logic HFOSC_EN,
	output logic HFOSC_READY,
	output logic REG_SHUTDOWN,
	output logic CORE_RESET,
	output logic WAKE_IRQ,
	output pmc_pkg::pmc_state_t POWER_MODE
);
	import pmc_pkg::*;

	localparam logic [15:0] SETTLE_LAST = 16'(`PMC_OSC_SETTLE_CYC - 1);

	pmc_regs_t r;
	pmc_regs_t n;
	logic pin_rst;
	logic soft_rst;
	logic any_rst;
	logic wr_hit;
	logic rd_hit;
	logic arm_wr;
	logic stop_req;
	logic idle_req;
	logic susp_req;

	always_comb begin
		n = r;
		// Two-flop pin synchronisers; logic reads only the second stage
		n.pin_sync = {r.pin_sync[0], RST_PIN_N};
		n.resume_sync = {r.resume_sync[0], USB_RESUME};
		pin_rst = !r.pin_sync[1];
		soft_rst = OTHER_RST_REQ | (CLK_LOSS_EN & CLK_LOSS_TIMEOUT); // RULE_04
		// With the regulator down only the pin reaches the core
		any_rst = pin_rst | (soft_rst & !r.reg_off); // RULE_07
		// Address alone selects the register, so every page sees it
		// Flags take any write of a running CPU, suspend included; mode requests only in run
		wr_hit = SFR_REQ.wr && (SFR_REQ.addr == `PMC_PWR_REQ_ADDR) && r.cpu_clk_en; // RULE_17
		rd_hit = SFR_REQ.rd && (SFR_REQ.addr == `PMC_PWR_REQ_ADDR); // RULE_17
		arm_wr = wr_hit && (r.st == PMC_RUN);
		n.rdata = rd_hit ? {r.gen_flags, 2'b00} : 8'h00; // RULE_15
		n.wake_irq = 1'b0;
		stop_req = r.stop_arm | (arm_wr & SFR_REQ.wdata[`PMC_STOP_BIT]); // RULE_15
		idle_req = r.idle_arm | (arm_wr & SFR_REQ.wdata[`PMC_IDLE_BIT]); // RULE_15
		susp_req = r.susp_arm | (SUSPEND_WR & (r.st == PMC_RUN));
		if (wr_hit) begin
			n.gen_flags = SFR_REQ.wdata[`PMC_FLAGS_MSB:`PMC_FLAGS_LSB]; // RULE_14
		end
		n.stop_arm = stop_req;
		n.idle_arm = idle_req;
		n.susp_arm = susp_req;
		unique case (r.st)
			PMC_RUN: begin
				// Requests take effect once the writing instruction ends
				if (INSTR_DONE) begin
					if (stop_req) begin
						n.st = PMC_STOP; // RULE_01
						n.reg_off = STOP_REG_CFG; // RULE_06 RULE_19
					end else if (idle_req) begin
						n.st = PMC_IDLE;
					end else if (susp_req) begin
						n.st = PMC_SUSPEND; // RULE_08
					end
					n.stop_arm = 1'b0;
					n.idle_arm = 1'b0;
					n.susp_arm = 1'b0;
				end
			end
			PMC_IDLE: begin
				if (IRQ_PENDING) begin
					n.st = PMC_RUN; // RULE_18
				end
			end
			PMC_STOP: begin
				// Nothing but a reset leaves stop
				n.st = PMC_STOP; // RULE_03
			end
			PMC_SUSPEND: begin
				if (r.resume_sync[1]) begin
					n.st = PMC_WAKE; // RULE_10
					n.cnt = 16'h0000;
				end
			end
			PMC_WAKE: begin
				// Oscillator restarted; hold its consumers until it settles
				n.cnt = r.cnt + 16'h0001; // RULE_20
				if (r.cnt == SETTLE_LAST) begin
					n.st = PMC_RUN; // RULE_11
					n.wake_irq = WAKE_IRQ_EN; // RULE_12
				end
			end
			PMC_RESET_SEQ: begin
				// Reset sequence also covers oscillator start-up
				n.cnt = r.cnt + 16'h0001;
				if (r.cnt == SETTLE_LAST) begin
					n.st = PMC_RUN;
				end
			end
		endcase
		if (any_rst) begin
			n.st = PMC_RESET_SEQ; // RULE_03 RULE_13
			n.cnt = 16'h0000;
			n.stop_arm = 1'b0;
			n.idle_arm = 1'b0;
			n.susp_arm = 1'b0;
			n.reg_off = 1'b0;
			n.gen_flags = 6'h00; // RULE_14
			n.wake_irq = 1'b0;
		end
		// Outputs follow the next state so they leave straight from flops
		n.core_reset = (n.st == PMC_RESET_SEQ); // RULE_03 RULE_13
		n.cpu_clk_en = (n.st == PMC_RUN) ||
			((n.st == PMC_SUSPEND || n.st == PMC_WAKE) && !SYSCLK_IS_HFOSC); // RULE_09 RULE_16
		n.periph_clk_en = (n.st != PMC_STOP); // RULE_02 RULE_16
		n.hfosc_en = (n.st != PMC_STOP) && (n.st != PMC_SUSPEND); // RULE_02 RULE_08 RULE_20
		n.hfosc_ready = (n.st == PMC_RUN) || (n.st == PMC_IDLE); // RULE_20
		n.reg_shutdown = (n.st == PMC_STOP) && n.reg_off; // RULE_06
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESETN) begin
			r.st <= PMC_RESET_SEQ;
			r.stop_arm <= 1'b0;
			r.idle_arm <= 1'b0;
			r.susp_arm <= 1'b0;
			r.reg_off <= 1'b0;
			r.gen_flags <= 6'h00;
			r.cnt <= 16'h0000;
			r.pin_sync <= 2'h3;
			r.resume_sync <= 2'h0;
			r.rdata <= `PMC_PWR_REQ_RESET;
			r.cpu_clk_en <= 1'b0;
			r.periph_clk_en <= 1'b1;
			r.hfosc_en <= 1'b1;
			r.hfosc_ready <= 1'b0;
			r.reg_shutdown <= 1'b0;
			r.core_reset <= 1'b1;
			r.wake_irq <= 1'b0;
		end else begin
			r <= n;
		end
	end

	assign SFR_RDATA = r.rdata;
	assign CPU_CLK_EN = r.cpu_clk_en;
	assign PERIPH_CLK_EN = r.periph_clk_en;
	assign HFOSC_EN = r.hfosc_en;
	assign HFOSC_READY = r.hfosc_ready;
	assign REG_SHUTDOWN = r.reg_shutdown;
	assign CORE_RESET = r.core_reset;
	assign WAKE_IRQ = r.wake_irq;
	assign POWER_MODE = r.st;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESETN);

	stop_entry_a: assert property ( // RULE_01
		(r.st == PMC_RUN && INSTR_DONE && (r.stop_arm || (wr_hit && SFR_REQ.wdata[`PMC_STOP_BIT])) && !any_rst)
		|=> (POWER_MODE == PMC_STOP) && !CPU_CLK_EN)
		else $error("stop not entered after instruction end");

	stop_clocks_a: assert property ( // RULE_02
		(r.st == PMC_STOP) |-> (!CPU_CLK_EN && !PERIPH_CLK_EN && !HFOSC_EN))
		else $error("clock still running in stop");

	stop_hold_a: assert property ( // RULE_03
		(r.st == PMC_STOP && !any_rst) |=> (r.st == PMC_STOP) && !CORE_RESET)
		else $error("stop left without reset");

	clk_loss_a: assert property ( // RULE_04
		(r.st == PMC_STOP && CLK_LOSS_EN && CLK_LOSS_TIMEOUT && !r.reg_off)
		|=> CORE_RESET && (r.cnt == 16'h0000))
		else $error("clock-loss timeout did not reset");

	reg_off_a: assert property ( // RULE_06
		REG_SHUTDOWN |-> (r.st == PMC_STOP) && r.reg_off)
		else $error("regulator shut down outside configured stop");

	pin_only_a: assert property ( // RULE_07
		(r.st == PMC_STOP && r.reg_off && r.pin_sync[1]) |=> !CORE_RESET)
		else $error("non-pin reset accepted with regulator off");

	pin_reset_a: assert property ( // RULE_03
		(!RST_PIN_N ##1 !RST_PIN_N) |-> ##2 CORE_RESET)
		else $error("pin reset not seen within three cycles");

	susp_cpu_a: assert property ( // RULE_09
		(r.st == PMC_SUSPEND && $past(r.st) == PMC_SUSPEND) |-> (CPU_CLK_EN == !$past(SYSCLK_IS_HFOSC)) && !HFOSC_EN)
		else $error("suspend clocking wrong");

	susp_wake_a: assert property ( // RULE_10
		(r.st == PMC_SUSPEND && r.resume_sync[1] && !any_rst) |=> HFOSC_EN && !HFOSC_READY && (r.st == PMC_WAKE))
		else $error("resume did not start wake");

	wake_done_a: assert property ( // RULE_20
		(r.st == PMC_WAKE && r.cnt == SETTLE_LAST && !any_rst)
		|=> HFOSC_READY && (WAKE_IRQ == $past(WAKE_IRQ_EN)) && (r.st == PMC_RUN))
		else $error("wake did not finish after settling");

	flags_reset_a: assert property ( // RULE_14
		(r.st == PMC_RESET_SEQ) |-> (r.gen_flags == 6'h00))
		else $error("flags not cleared by reset");

	read_zero_a: assert property ( // RULE_15
		rd_hit |=> (SFR_RDATA[1:0] == 2'h0) && (SFR_RDATA[7:2] == $past(r.gen_flags)))
		else $error("register read value wrong");

	idle_clk_a: assert property ( // RULE_16
		(r.st == PMC_IDLE) |-> !CPU_CLK_EN && PERIPH_CLK_EN && HFOSC_EN)
		else $error("idle clock gating wrong");

	idle_wake_a: assert property ( // RULE_18
		(r.st == PMC_IDLE && IRQ_PENDING && !any_rst) |=> (r.st == PMC_RUN) && CPU_CLK_EN)
		else $error("interrupt did not end idle");

	idle_entry_a: assert property ( // RULE_16
		(r.st == PMC_RUN && INSTR_DONE && !stop_req && idle_req && !any_rst)
		|=> (POWER_MODE == PMC_IDLE) && !CPU_CLK_EN && PERIPH_CLK_EN)
		else $error("idle not entered after instruction end");

	susp_entry_a: assert property ( // RULE_08
		(r.st == PMC_RUN && INSTR_DONE && susp_req && !stop_req && !idle_req && !any_rst)
		|=> (POWER_MODE == PMC_SUSPEND) && !HFOSC_EN && !HFOSC_READY)
		else $error("suspend not entered after instruction end");

	arm_clear_a: assert property ( // RULE_15
		(r.st == PMC_RUN && INSTR_DONE) |=> !r.stop_arm && !r.idle_arm && !r.susp_arm)
		else $error("mode request left armed");

	run_hold_a: assert property ( // RULE_01
		(r.st == PMC_RUN && !INSTR_DONE && !any_rst) |=> (r.st == PMC_RUN) && !CORE_RESET)
		else $error("run left before instruction end");

	stop_regon_a: assert property ( // RULE_19
		(r.st == PMC_RUN && INSTR_DONE && stop_req && !STOP_REG_CFG && !any_rst)
		|=> (r.st == PMC_STOP) && !REG_SHUTDOWN && !r.reg_off)
		else $error("regulator shut down without configuration");

	stop_regoff_a: assert property ( // RULE_06
		(r.st == PMC_RUN && INSTR_DONE && stop_req && STOP_REG_CFG && !any_rst)
		|=> (r.st == PMC_STOP) && REG_SHUTDOWN && r.reg_off)
		else $error("configured regulator shutdown missing");

	regon_reset_a: assert property ( // RULE_19
		(r.st == PMC_STOP && !r.reg_off && OTHER_RST_REQ) |=> CORE_RESET && (r.st == PMC_RESET_SEQ))
		else $error("internal reset ignored with regulator on");

	regoff_pin_a: assert property ( // RULE_07
		(r.st == PMC_STOP && r.reg_off && !r.pin_sync[1]) |=> CORE_RESET && !REG_SHUTDOWN)
		else $error("pin reset ignored with regulator off");

	reset_entry_a: assert property ( // RULE_13
		any_rst |=> CORE_RESET && (POWER_MODE == PMC_RESET_SEQ) && !CPU_CLK_EN && (r.cnt == 16'h0000))
		else $error("reset did not start reset sequence");

	reset_exit_a: assert property ( // RULE_03
		(r.st == PMC_RESET_SEQ && r.cnt == SETTLE_LAST && !any_rst)
		|=> (POWER_MODE == PMC_RUN) && !CORE_RESET && CPU_CLK_EN && HFOSC_READY)
		else $error("reset sequence did not end in run");

	run_clocks_a: assert property ( // RULE_11
		(r.st == PMC_RUN) |-> CPU_CLK_EN && PERIPH_CLK_EN && HFOSC_EN && HFOSC_READY && !CORE_RESET)
		else $error("run clocking wrong");

	susp_hold_a: assert property ( // RULE_10
		(r.st == PMC_SUSPEND && !r.resume_sync[1] && !any_rst) |=> (r.st == PMC_SUSPEND))
		else $error("suspend left without wake event");

	susp_osc_a: assert property ( // RULE_08
		(r.st == PMC_SUSPEND) |-> !HFOSC_EN && !HFOSC_READY && PERIPH_CLK_EN && !CORE_RESET)
		else $error("oscillator running in suspend");

	susp_keep_a: assert property ( // RULE_09
		(r.st == PMC_SUSPEND && !wr_hit && !any_rst) |=> (r.gen_flags == $past(r.gen_flags)))
		else $error("flags lost in suspend");

	flag_write_a: assert property ( // RULE_14
		(wr_hit && !any_rst) |=> (r.gen_flags == $past(SFR_REQ.wdata[`PMC_FLAGS_MSB:`PMC_FLAGS_LSB])))
		else $error("flag write not stored");

	wake_hold_a: assert property ( // RULE_20
		(r.st == PMC_WAKE) |-> HFOSC_EN && !HFOSC_READY && !CORE_RESET)
		else $error("oscillator not settling during wake");

	wake_irq_src_a: assert property ( // RULE_12
		WAKE_IRQ |-> ($past(r.st) == PMC_WAKE) && (POWER_MODE == PMC_RUN))
		else $error("wake interrupt outside wake completion");

	wake_pulse_a: assert property ( // RULE_12
		WAKE_IRQ |=> !WAKE_IRQ)
		else $error("wake interrupt longer than one cycle");

	idle_hold_a: assert property ( // RULE_18
		(r.st == PMC_IDLE && !IRQ_PENDING && !any_rst) |=> (r.st == PMC_IDLE) && !CPU_CLK_EN)
		else $error("idle left without interrupt");

	write_other_a: assert property ( // RULE_17
		(SFR_REQ.wr && SFR_REQ.addr != `PMC_PWR_REQ_ADDR && !any_rst) |=> (r.gen_flags == $past(r.gen_flags)))
		else $error("flags changed by foreign address");

	rd_other_a: assert property ( // RULE_17
		(SFR_REQ.rd && SFR_REQ.addr != `PMC_PWR_REQ_ADDR) |=> (SFR_RDATA == 8'h00))
		else $error("foreign address read not zero");

	stop_cov_c: cover property (r.st == PMC_RUN ##1 r.st == PMC_STOP ##[1:20] CORE_RESET);
	idle_cov_c: cover property (r.st == PMC_IDLE ##1 r.st == PMC_RUN);
	wake_cov_c: cover property (r.st == PMC_WAKE ##1 WAKE_IRQ);
	regoff_cov_c: cover property (REG_SHUTDOWN ##1 !RST_PIN_N);
	susp_flag_cov_c: cover property (r.st == PMC_SUSPEND && wr_hit);

endmodule
`default_nettype wire

// File: include/pmc_regs.svh
// Register offsets, field positions, reset values and timing counts of the power mode control block
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// Power mode request register, visible on every special-function page
`define PMC_PWR_REQ_ADDR 8'h87
`define PMC_PWR_REQ_RESET 8'h00
`define PMC_IDLE_BIT 0
`define PMC_STOP_BIT 1
`define PMC_FLAGS_LSB 2
`define PMC_FLAGS_MSB 7

// Fields of neighbouring registers that reach this block as plain signals
`define PMC_SUSPEND_BIT 5
`define PMC_STOP_REG_CFG_BIT 3

// Timing
`define PMC_CLK_PERIOD_NS 10
`define PMC_OSC_SETTLE_NS 1000
`define PMC_OSC_SETTLE_CYC ((`PMC_OSC_SETTLE_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)

`endif

// File: include/pmc_pkg.sv
// Types shared by the power mode control block
package pmc_pkg;

	typedef enum logic [2:0] {
		PMC_RUN,
		PMC_IDLE,
		PMC_STOP,
		PMC_SUSPEND,
		PMC_WAKE,
		PMC_RESET_SEQ
	} pmc_state_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pmc_sfr_req_t;

	typedef struct packed {
		pmc_state_t st;
		logic stop_arm;
		logic idle_arm;
		logic susp_arm;
		logic reg_off;
		logic [5:0] gen_flags;
		logic [15:0] cnt;
		logic [1:0] pin_sync;
		logic [1:0] resume_sync;
		logic [7:0] rdata;
		logic cpu_clk_en;
		logic periph_clk_en;
		logic hfosc_en;
		logic hfosc_ready;
		logic reg_shutdown;
		logic core_reset;
		logic wake_irq;
	} pmc_regs_t;

endpackage

// File: sim/pmc_power_mode_control_bench.sv
// Self-checking bench for the power mode control block
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_power_mode_control_bench;
	import pmc_pkg::*;
	logic clk = 0, rstn = 0, instr_done = 0, susp_wr = 0, stop_cfg = 0, irq = 0, wake_en = 0, sys_hf = 1;
	logic usb = 0, pin_n = 1, oth_rst = 0, cl_en = 0, cl_to = 0;
	logic cpu_en, per_en, hf_en, hf_rdy, reg_sd, core_rst, wake_irq;
	logic [7:0] rdata, rd, w;
	pmc_sfr_req_t req = '0;
	pmc_state_t mode;
	int failures = 0, num_checks = 0, cycles = 0, irq_cnt = 0;
	localparam logic [7:0] ADR = `PMC_PWR_REQ_ADDR;
	always #5 clk = ~clk;
	pmc_power_mode_control uut (.CLK_SYS(clk), .RESETN(rstn), .SFR_REQ(req), .SFR_RDATA(rdata),
		.INSTR_DONE(instr_done), .SUSPEND_WR(susp_wr), .STOP_REG_CFG(stop_cfg), .IRQ_PENDING(irq),
		.WAKE_IRQ_EN(wake_en), .SYSCLK_IS_HFOSC(sys_hf), .USB_RESUME(usb), .RST_PIN_N(pin_n),
		.OTHER_RST_REQ(oth_rst), .CLK_LOSS_EN(cl_en), .CLK_LOSS_TIMEOUT(cl_to), .CPU_CLK_EN(cpu_en),
		.PERIPH_CLK_EN(per_en), .HFOSC_EN(hf_en), .HFOSC_READY(hf_rdy), .REG_SHUTDOWN(reg_sd),
		.CORE_RESET(core_rst), .WAKE_IRQ(wake_irq), .POWER_MODE(mode));
	// Cycle budget and wake pulse counting
	always @(posedge clk) begin
		cycles++;
		if (wake_irq === 1'b1) irq_cnt++;
		if (cycles == 4000) begin
			failures++;
			report_and_stop();
		end
	end
	task automatic step(int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_mode(pmc_state_t got, pmc_state_t exp);
		chk({5'h00, got}, {5'h00, exp});
	endtask
	function automatic logic [7:0] exp_rd(logic [7:0] d);
		return {d[7:2], 2'b00};
	endfunction
	task automatic sfr_wr(logic [7:0] a, logic [7:0] d);
		req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		step();
		req = '0;
		step();
	endtask
	task automatic sfr_rd(logic [7:0] a, output logic [7:0] d);
		req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		step();
		d = rdata;
		req = '0;
		step();
	endtask
	task automatic mode_req(logic s);
		instr_done = 1;
		susp_wr = s;
		step();
		instr_done = 0;
		susp_wr = 0;
		step();
	endtask
	task automatic waitm(pmc_state_t m, int n);
		int i;
		i = 0;
		while (mode !== m && i < n) begin
			step();
			i++;
		end
		chk_mode(mode, m);
	endtask
	task automatic done(string s);
		$display("test %s finished at %0t", s, $time);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(32'h9fab));
		step(6);
		chk({core_rst, cpu_en, 6'h00}, 8'h80);
		rstn = 1;
		waitm(PMC_RUN, 120);
		sfr_rd(ADR, rd);
		chk(rd, 8'h00);
		done("reset");
		repeat (4) begin
			w = 8'($urandom) & 8'hfc;
			sfr_wr(ADR, w);
			sfr_rd(ADR, rd);
			chk(rd, exp_rd(w));
		end
		sfr_wr(8'h86, 8'hff);
		sfr_rd(8'h86, rd);
		chk(rd, 8'h00);
		sfr_rd(ADR, rd);
		chk(rd, exp_rd(w));
		done("flags");
		sfr_wr(ADR, w | 8'h01);
		sfr_rd(ADR, rd);
		chk(rd, exp_rd(w));
		chk_mode(mode, PMC_RUN);
		mode_req(0);
		waitm(PMC_IDLE, 3);
		chk(8'({cpu_en, per_en}), 8'h01);
		irq = 1;
		waitm(PMC_RUN, 3);
		irq = 0;
		chk(8'(cpu_en), 8'h01);
		done("idle");
		wake_en = 1;
		mode_req(1);
		waitm(PMC_SUSPEND, 3);
		chk(8'({hf_en, hf_rdy, cpu_en}), 8'h00);
		usb = 1;
		irq_cnt = 0;
		waitm(PMC_WAKE, 6);
		usb = 0;
		chk(8'({hf_en, hf_rdy}), 8'h02);
		waitm(PMC_RUN, 110);
		step();
		chk(8'(hf_rdy), 8'h01);
		chk(8'(irq_cnt), 8'h01);
		sfr_rd(ADR, rd);
		chk(rd, exp_rd(w));
		done("suspend");
		stop_cfg = 1;
		// Detector off at entry to a stop meant to outlast its timeout
		cl_en = 0;
		sfr_wr(ADR, 8'h02);
		chk_mode(mode, PMC_RUN);
		mode_req(0);
		waitm(PMC_STOP, 3);
		chk(8'({per_en, cpu_en, hf_en, reg_sd}), 8'h01);
		oth_rst = 1;
		cl_en = 1;
		cl_to = 1;
		step(3);
		chk_mode(mode, PMC_STOP);
		oth_rst = 0;
		cl_en = 0;
		cl_to = 0;
		pin_n = 0;
		step(4);
		pin_n = 1;
		chk(8'(core_rst), 8'h01);
		waitm(PMC_RUN, 120);
		done("stop regulator off");
		stop_cfg = 0;
		w = 8'($urandom);
		sfr_wr(ADR, {w[7:2], 2'b11});
		mode_req(1);
		waitm(PMC_STOP, 3);
		chk(8'(reg_sd), 8'h00);
		cl_en = 1;
		cl_to = 1;
		step();
		cl_to = 0;
		cl_en = 0;
		waitm(PMC_RESET_SEQ, 4);
		waitm(PMC_RUN, 120);
		sfr_rd(ADR, rd);
		chk(rd, 8'h00);
		done("stop clock loss");
		sys_hf = 0;
		wake_en = 0;
		mode_req(1);
		waitm(PMC_SUSPEND, 3);
		chk(8'({cpu_en, hf_en}), 8'h02);
		w = 8'($urandom);
		sfr_wr(ADR, w);
		sfr_rd(ADR, rd);
		chk(rd, exp_rd(w));
		chk_mode(mode, PMC_SUSPEND);
		usb = 1;
		irq_cnt = 0;
		waitm(PMC_WAKE, 6);
		usb = 0;
		chk(8'({cpu_en, hf_en, hf_rdy}), 8'h06);
		waitm(PMC_RUN, 110);
		step();
		chk(8'(irq_cnt), 8'h00);
		sfr_rd(ADR, rd);
		chk(rd, exp_rd(w));
		done("suspend other clock");
		mode_req(1);
		waitm(PMC_SUSPEND, 3);
		chk(8'({cpu_en, hf_en}), 8'h02);
		oth_rst = 1;
		step();
		oth_rst = 0;
		waitm(PMC_RESET_SEQ, 4);
		chk(8'(hf_en), 8'h01);
		waitm(PMC_RUN, 120);
		done("suspend reset");
		report_and_stop();
	end
endmodule
`default_nettype wire
